// File: hdl/spsm_pkg.sv
// constants and types for the secondary audio port receive slot mapper
// assumes an 8-bit register port and 32-bit slots on the serial link
package spsm_pkg;

    localparam int NUM_CH = 3;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [7:0] ADDR_FMT = 8'h24;
    localparam logic [7:0] ADDR_STATUS = 8'h25;
    localparam logic [7:0] ADDR_OFFSET = 8'h26;
    localparam logic [7:0] ADDR_PINSEL = 8'h27;
    localparam logic [7:0] ADDR_CH1 = 8'h28;
    localparam logic [7:0] ADDR_CH2 = 8'h29;
    localparam logic [7:0] ADDR_CH3 = 8'h2A;

    // channel configuration field layout
    localparam int ENABLE_BIT = 5;
    localparam int SLOT_W = 5;
    localparam int CFG_W = 6;
    localparam logic [7:0] CFG_WR_MASK = 8'h3F;

    // reset values
    localparam logic [7:0] CH_RESET [NUM_CH] = '{8'h00, 8'h01, 8'h02};
    localparam logic [4:0] OFFSET_RESET = 5'h00;
    localparam logic [2:0] PINSEL_RESET = 3'h0;
    localparam int OFFSET_W = 5;

    // serial framing
    localparam int WORD_BITS = 32;
    localparam int SLOT_SHIFT = 5;
    localparam int POS_W = 10;
    localparam logic [4:0] LAST_BIT = 5'h1F;

    // frame formats; code 2'b11 behaves as time-division
    typedef enum logic [1:0]
    {
        SPSM_FMT_TDM = 2'b00,
        SPSM_FMT_I2S = 2'b01,
        SPSM_FMT_LEFT_JUSTIFIED = 2'b10,
        SPSM_FMT_RSVD = 2'b11
    } spsm_fmt_e;

endpackage

// File: hdl/spsm_sync.sv
// two-flop synchroniser for levels and toggles
// assumes each bit changes at most once per few destination clocks
`timescale 1ns/1ns
`default_nettype none
module spsm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta <= '0;
            q_o <= '0;
        end
        else
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire

// File: hdl/spsm_rx_slot_mapper.sv
// receive slot mapper of the secondary audio port, three channels
// assumes bclk_i, fsync_i and both data pins come from the audio host
// and change after the bclk rising edge; registers run on clock_i
//
// Notes on behaviour
// RL1 - channel 1 enable bit 5 set routes channel 1 samples to DAC 1
// RL2 - channel 2 enable bit 5 set routes channel 2 samples to DAC 2
// RL3 - slot field 0..15 picks TDM slot n or left-half slot n
// RL4 - slot field 16..31 picks TDM slot n or right-half slot n-16
// RL5 - bits 7:6 of channel registers are reserved, read zero, writes ignored
// RL6 - channel 1 register at 0x28, reset 0x00: disabled, slot 0
// RL7 - channel 2 register at 0x29, reset 0x01: disabled, slot 1
// RL8 - channel 3 register at 0x2A, reset 0x02: disabled, slot 2
// RL9 - per-channel pin select: clear takes primary input, set the second input
// RL10 - slot 0 MSB delayed by a 0..31 bit-clock offset field
// RL11 - disabled channel ignores its slot and forwards nothing
`timescale 1ns/1ns
`default_nettype none
module spsm_rx_slot_mapper (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [spsm_pkg::ADDR_W-1:0] addr_i,
    input wire logic [spsm_pkg::DATA_W-1:0] wr_data_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [spsm_pkg::DATA_W-1:0] rd_data_o,
    input wire logic bclk_i,
    input wire logic fsync_i,
    input wire logic primary_data_input_i,
    input wire logic second_data_input_i,
    output logic [spsm_pkg::WORD_BITS-1:0] dac_ch1_data_o,
    output logic [spsm_pkg::WORD_BITS-1:0] dac_ch2_data_o,
    output logic [spsm_pkg::WORD_BITS-1:0] dac_ch3_data_o,
    output logic dac_ch1_valid_o,
    output logic dac_ch2_valid_o,
    output logic dac_ch3_valid_o
);
    import spsm_pkg::*;

    function automatic logic [1:0] ch_index(input logic [7:0] a);
        if (a == ADDR_CH1)
            return 2'd0;
        else if (a == ADDR_CH2)
            return 2'd1;
        else if (a == ADDR_CH3)
            return 2'd2;
        else
            return 2'd3;
    endfunction

    // register domain
    logic [CFG_W-1:0] ch_cfg [NUM_CH];
    logic [OFFSET_W-1:0] rx_msb_offset;
    logic [NUM_CH-1:0] pin_select;
    spsm_fmt_e fmt;
    logic [1:0] wr_idx;
    logic cfg_wr;
    logic dirty;
    logic launch;
    logic cfg_req;
    logic cfg_ack_s;
    logic frame_tog_s;
    logic [CFG_W-1:0] bus_cfg [NUM_CH];
    logic [OFFSET_W-1:0] bus_off;
    logic [NUM_CH-1:0] bus_pin;
    spsm_fmt_e bus_fmt;
    logic [NUM_CH-1:0] tog_s;
    logic [NUM_CH-1:0] tog_q;
    logic [WORD_BITS-1:0] out_data [NUM_CH];
    logic [NUM_CH-1:0] out_valid;

    // link domain
    logic lrst_b;
    logic req_s;
    logic lk_req_q;
    logic [CFG_W-1:0] lk_cfg [NUM_CH];
    logic [OFFSET_W-1:0] lk_off;
    logic [NUM_CH-1:0] lk_pin;
    spsm_fmt_e lk_fmt;
    logic fs_q;
    logic synced;
    logic half;
    logic half_cur;
    logic [POS_W-1:0] cnt;
    logic [POS_W-1:0] cur;
    logic [POS_W-1:0] eff_off;
    logic [POS_W-1:0] rel;
    logic [SLOT_W-1:0] slot_raw;
    logic [SLOT_W-1:0] eff_slot;
    logic [SLOT_SHIFT-1:0] bitn;
    logic i2s;
    logic pair;
    logic frame_start;
    logic half_start;
    logic active;
    logic [NUM_CH-1:0] hit;
    logic [NUM_CH-1:0] tog;
    logic frame_tog;
    logic [WORD_BITS-2:0] sh [NUM_CH];
    logic [WORD_BITS-1:0] hold [NUM_CH];

    assign wr_idx = ch_index(addr_i);
    assign cfg_wr = wr_i && (wr_idx != 2'd3 || addr_i == ADDR_FMT
        || addr_i == ADDR_OFFSET || addr_i == ADDR_PINSEL);
    // a new snapshot only leaves once the previous one is acknowledged
    assign launch = dirty && (cfg_req == cfg_ack_s);

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            for (int k = 0; k < NUM_CH; k++)
                ch_cfg[k] <= CH_RESET[k][CFG_W-1:0]; // RL6 RL7 RL8
            rx_msb_offset <= OFFSET_RESET;
            pin_select <= PINSEL_RESET;
            fmt <= SPSM_FMT_TDM;
        end
        else if (wr_i)
        begin
            if (wr_idx != 2'd3)
                ch_cfg[wr_idx] <= wr_data_i[CFG_W-1:0]; // RL5
            else if (addr_i == ADDR_FMT)
                fmt <= spsm_fmt_e'(wr_data_i[1:0]);
            else if (addr_i == ADDR_OFFSET)
                rx_msb_offset <= wr_data_i[OFFSET_W-1:0];
            else if (addr_i == ADDR_PINSEL)
                pin_select <= wr_data_i[NUM_CH-1:0];
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rd_data_o <= '0;
        else if (!rd_i)
            rd_data_o <= '0;
        else if (ch_index(addr_i) != 2'd3)
            rd_data_o <= {2'b00, ch_cfg[ch_index(addr_i)]}; // RL5
        else if (addr_i == ADDR_FMT)
            rd_data_o <= {6'h00, fmt};
        else if (addr_i == ADDR_STATUS)
            rd_data_o <= {6'h00, frame_tog_s, cfg_req != cfg_ack_s};
        else if (addr_i == ADDR_OFFSET)
            rd_data_o <= {3'h0, rx_msb_offset};
        else if (addr_i == ADDR_PINSEL)
            rd_data_o <= {5'h00, pin_select};
        else
            rd_data_o <= '0;
    end

    // a write in the launch cycle keeps dirty set so it is sent next
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            dirty <= 1'b0;
        else if (cfg_wr)
            dirty <= 1'b1;
        else if (launch)
            dirty <= 1'b0;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cfg_req <= 1'b0;
            for (int k = 0; k < NUM_CH; k++)
                bus_cfg[k] <= CH_RESET[k][CFG_W-1:0];
            bus_off <= OFFSET_RESET;
            bus_pin <= PINSEL_RESET;
            bus_fmt <= SPSM_FMT_TDM;
        end
        else if (launch)
        begin
            cfg_req <= ~cfg_req;
            bus_cfg <= ch_cfg;
            bus_off <= rx_msb_offset;
            bus_pin <= pin_select;
            bus_fmt <= fmt;
        end
    end

    spsm_sync #(.WIDTH(2)) u_sync_sys (
        .clk_i(clock_i),
        .rst_b_i(rst_b_i),
        .d_i({lk_req_q, frame_tog}),
        .q_o({cfg_ack_s, frame_tog_s})
    );

    spsm_sync #(.WIDTH(NUM_CH)) u_sync_tog (
        .clk_i(clock_i),
        .rst_b_i(rst_b_i),
        .d_i(tog),
        .q_o(tog_s)
    );

    // hold[] is stable for a whole slot after its toggle flips
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            tog_q <= '0;
            out_valid <= '0;
            for (int k = 0; k < NUM_CH; k++)
                out_data[k] <= '0;
        end
        else
        begin
            tog_q <= tog_s;
            for (int k = 0; k < NUM_CH; k++)
            begin
                out_valid[k] <= tog_s[k] != tog_q[k];
                if (tog_s[k] != tog_q[k])
                    out_data[k] <= hold[k];
            end
        end
    end

    assign dac_ch1_data_o = out_data[0];
    assign dac_ch2_data_o = out_data[1];
    assign dac_ch3_data_o = out_data[2];
    assign dac_ch1_valid_o = out_valid[0];
    assign dac_ch2_valid_o = out_valid[1];
    assign dac_ch3_valid_o = out_valid[2];

    // link reset: asserted at once, released on bclk
    spsm_sync #(.WIDTH(1)) u_sync_rst (
        .clk_i(bclk_i),
        .rst_b_i(rst_b_i),
        .d_i(1'b1),
        .q_o(lrst_b)
    );

    spsm_sync #(.WIDTH(1)) u_sync_req (
        .clk_i(bclk_i),
        .rst_b_i(lrst_b),
        .d_i(cfg_req),
        .q_o(req_s)
    );

    always_ff @(posedge bclk_i or negedge lrst_b)
    begin
        if (!lrst_b)
        begin
            lk_req_q <= 1'b0;
            for (int k = 0; k < NUM_CH; k++)
                lk_cfg[k] <= CH_RESET[k][CFG_W-1:0];
            lk_off <= OFFSET_RESET;
            lk_pin <= PINSEL_RESET;
            lk_fmt <= SPSM_FMT_TDM;
        end
        else if (req_s != lk_req_q)
        begin
            lk_req_q <= req_s;
            lk_cfg <= bus_cfg;
            lk_off <= bus_off;
            lk_pin <= bus_pin;
            lk_fmt <= bus_fmt;
        end
    end

    assign i2s = lk_fmt == SPSM_FMT_I2S;
    assign pair = i2s || lk_fmt == SPSM_FMT_LEFT_JUSTIFIED;
    // i2s frames open on the falling frame sync, the others on the rising
    assign frame_start = i2s ? (fs_q && !fsync_i) : (!fs_q && fsync_i);
    assign half_start = pair && (i2s ? (!fs_q && fsync_i)
        : (fs_q && !fsync_i));

    always_comb
    begin
        if (frame_start || half_start)
            cur = '0;
        else if (&cnt)
            cur = cnt;
        else
            cur = cnt + 1'b1;
        half_cur = half_start || (half && !frame_start);
        // i2s carries its MSB one bit after the frame edge
        eff_off = POS_W'(lk_off) + POS_W'(i2s); // RL10
        rel = cur - eff_off;
        slot_raw = rel[POS_W-1:SLOT_SHIFT];
        bitn = rel[SLOT_SHIFT-1:0];
        if (pair)
            eff_slot = {half_cur, slot_raw[SLOT_W-2:0]}; // RL3 RL4
        else
            eff_slot = slot_raw; // RL3 RL4
        active = (synced || frame_start) && cur >= eff_off
            && !(pair && slot_raw[SLOT_W-1]);
        for (int k = 0; k < NUM_CH; k++)
            hit[k] = active && lk_cfg[k][ENABLE_BIT] // RL1 RL2 RL11
                && eff_slot == lk_cfg[k][SLOT_W-1:0];
    end

    always_ff @(posedge bclk_i or negedge lrst_b)
    begin
        if (!lrst_b)
        begin
            fs_q <= 1'b0;
            synced <= 1'b0;
            half <= 1'b0;
            cnt <= '0;
            frame_tog <= 1'b0;
        end
        else
        begin
            fs_q <= fsync_i;
            half <= half_cur;
            cnt <= cur;
            if (frame_start)
            begin
                synced <= 1'b1;
                frame_tog <= ~frame_tog;
            end
        end
    end

    always_ff @(posedge bclk_i or negedge lrst_b)
    begin
        if (!lrst_b)
        begin
            tog <= '0;
            for (int k = 0; k < NUM_CH; k++)
            begin
                sh[k] <= '0;
                hold[k] <= '0;
            end
        end
        else
        begin
            for (int k = 0; k < NUM_CH; k++)
            begin
                if (hit[k])
                begin
                    sh[k] <= {sh[k][WORD_BITS-3:0], lk_pin[k] // RL9
                        ? second_data_input_i : primary_data_input_i};
                    if (bitn == LAST_BIT)
                    begin
                        hold[k] <= {sh[k], lk_pin[k]
                            ? second_data_input_i : primary_data_input_i};
                        tog[k] <= ~tog[k]; // RL1 RL2
                    end
                end
            end
        end
    end

    // checks
    logic [NUM_CH-1:0] ch_written;

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            ch_written <= '0;
        else if (wr_i && wr_idx != 2'd3)
            ch_written[wr_idx] <= 1'b1;
    end

    reserved_zero_a: assert property ( // RL5
        @(posedge clock_i) disable iff (!rst_b_i)
        rd_i && ch_index(addr_i) != 2'd3 |=> rd_data_o[7:6] == 2'b00)
        else $error("reserved bits read nonzero");

    ch1_write_read_a: assert property ( // RL6
        @(posedge clock_i) disable iff (!rst_b_i)
        wr_i && addr_i == ADDR_CH1 ##1 rd_i && addr_i == ADDR_CH1
        |=> rd_data_o == ($past(wr_data_i, 2) & CFG_WR_MASK))
        else $error("channel 1 register did not hold written value");

    ch2_reset_value_a: assert property ( // RL7
        @(posedge clock_i) disable iff (!rst_b_i)
        rd_i && addr_i == ADDR_CH2 && !ch_written[1]
        |=> rd_data_o == CH_RESET[1])
        else $error("channel 2 reset value wrong");

    ch3_reset_value_a: assert property ( // RL8
        @(posedge clock_i) disable iff (!rst_b_i)
        rd_i && addr_i == ADDR_CH3 && !ch_written[2]
        |=> rd_data_o == CH_RESET[2])
        else $error("channel 3 reset value wrong");

    ch1_word_done_a: assert property ( // RL1
        @(posedge bclk_i) disable iff (!lrst_b)
        tog[0] != $past(tog[0])
        |-> $past(lk_cfg[0][ENABLE_BIT]) && $past(bitn) == LAST_BIT)
        else $error("channel 1 word from disabled channel");

    ch2_word_done_a: assert property ( // RL2
        @(posedge bclk_i) disable iff (!lrst_b)
        tog[1] != $past(tog[1])
        |-> $past(lk_cfg[1][ENABLE_BIT]) && $past(hit[1]))
        else $error("channel 2 word without a slot hit");

    left_half_slot_a: assert property ( // RL3
        @(posedge bclk_i) disable iff (!lrst_b)
        hit[0] && pair && !lk_cfg[0][SLOT_W-1]
        |-> !half_cur && slot_raw == lk_cfg[0][SLOT_W-1:0])
        else $error("low slot taken outside left half");

    right_half_slot_a: assert property ( // RL4
        @(posedge bclk_i) disable iff (!lrst_b)
        hit[1] && pair && lk_cfg[1][SLOT_W-1]
        |-> half_cur && slot_raw[SLOT_W-2:0] == lk_cfg[1][SLOT_W-2:0])
        else $error("high slot taken outside right half");

    pin_source_a: assert property ( // RL9
        @(posedge bclk_i) disable iff (!lrst_b)
        hit[0] |=> sh[0][0] == $past(lk_pin[0] ? second_data_input_i
            : primary_data_input_i))
        else $error("channel 1 sampled the wrong data pin");

    msb_offset_a: assert property ( // RL10
        @(posedge bclk_i) disable iff (!lrst_b)
        hit[2] |-> cur >= POS_W'(lk_off) && (lk_fmt != SPSM_FMT_I2S
            || cur > POS_W'(lk_off)))
        else $error("sample taken before offset MSB position");

    disabled_hold_a: assert property ( // RL11
        @(posedge bclk_i) disable iff (!lrst_b)
        !lk_cfg[2][ENABLE_BIT] |=> $stable(sh[2]) && $stable(tog[2]))
        else $error("disabled channel 3 still shifting");

    ch1_sample_c: cover property (
        @(posedge clock_i) disable iff (!rst_b_i) dac_ch1_valid_o);
    right_half_c: cover property (
        @(posedge bclk_i) disable iff (!lrst_b) hit[1] && pair && half_cur);
    offset_hit_c: cover property (
        @(posedge bclk_i) disable iff (!lrst_b) hit[0] && lk_off != '0);
    cfg_launch_c: cover property (
        @(posedge clock_i) disable iff (!rst_b_i) launch ##1 cfg_wr);
endmodule
`default_nettype wire

// File: tb/spsm_host_model.sv
// audio host model: bit clock, frame sync and two serial data pins
// assumes the receiver samples every pin on the bit clock rising edge
`timescale 1ns/1ns
`default_nettype none
module spsm_host_model (
    output logic bclk_o,
    output logic fsync_o,
    output logic data_a_o,
    output logic data_b_o
);
    import spsm_pkg::*;
    logic [31:0] word_a [32];
    logic [31:0] word_b [32];
    initial
    begin
        bclk_o = 1'b0;
        fsync_o = 1'b0;
        data_a_o = 1'b0;
        data_b_o = 1'b1;
    end
    // the clock runs only for a frame and a 16-bit lead-in; a register burst
    // needs two handshake round trips on this clock before it lands, plus
    // two edges of link reset release on the very first frame
    // slots are indexed by the slot field
    task automatic send_frame(input logic [1:0] fmt, input int off,
        input int nbits);
        int half;
        int j;
        int idx;
        logic idle;
        idle = (fmt == SPSM_FMT_I2S);
        half = (fmt == SPSM_FMT_I2S
            || fmt == SPSM_FMT_LEFT_JUSTIFIED) ? 512 : 1024;
        #37;
        for (int pos = -16; pos < nbits; pos++)
        begin
            j = (pos % half) - off - int'(idle);
            idx = j / 32 + ((pos >= half) ? 16 : 0);
            if (pos < 0)
                fsync_o = idle;
            else if (half == 1024)
                fsync_o = (pos == 0);
            else
                fsync_o = (pos < 512) ^ idle;
            if (pos >= 0 && j >= 0 && j / 32 < half / 32)
            begin
                data_a_o = word_a[idx][31 - j % 32];
                data_b_o = word_b[idx][31 - j % 32];
            end
            else
            begin
                // no slot here: keep toggling so stale bits never pass
                data_a_o = ~data_a_o;
                data_b_o = ~data_b_o;
            end
            #62 bclk_o = 1'b1;
            #63 bclk_o = 1'b0;
        end
        data_a_o = ~data_a_o;
        data_b_o = ~data_b_o;
    endtask
endmodule
`default_nettype wire

// File: tb/secondary_port_rx_slot_mapper_tb.sv
// self-checking bench for the receive slot mapper
// assumes the host model owns the link and the bench the register port
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
        end \
    end
module secondary_port_rx_slot_mapper_tb;
    import spsm_pkg::*;
    logic clock_i = 1'b0;
    logic rst_b_i;
    logic [7:0] addr_i;
    logic [7:0] wr_data_i;
    logic wr_i;
    logic rd_i;
    logic [7:0] rd_data_o;
    logic bclk;
    logic fsync;
    logic din_a;
    logic din_b;
    logic [31:0] dac_data [3];
    logic [2:0] dac_valid;
    int num_errors = 0;
    int cmp_count = 0;
    int vcnt [3] = '{0, 0, 0};
    logic [31:0] vdat [3];

    spsm_rx_slot_mapper u_dut (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .addr_i(addr_i),
        .wr_data_i(wr_data_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rd_data_o(rd_data_o),
        .bclk_i(bclk),
        .fsync_i(fsync),
        .primary_data_input_i(din_a),
        .second_data_input_i(din_b),
        .dac_ch1_data_o(dac_data[0]),
        .dac_ch2_data_o(dac_data[1]),
        .dac_ch3_data_o(dac_data[2]),
        .dac_ch1_valid_o(dac_valid[0]),
        .dac_ch2_valid_o(dac_valid[1]),
        .dac_ch3_valid_o(dac_valid[2])
    );

    spsm_host_model u_host (
        .bclk_o(bclk),
        .fsync_o(fsync),
        .data_a_o(din_a),
        .data_b_o(din_b)
    );

    always #50 clock_i = ~clock_i;

    always @(posedge clock_i)
        for (int k = 0; k < 3; k++)
            if (dac_valid[k] === 1'b1)
            begin
                vcnt[k]++;
                vdat[k] = dac_data[k];
            end

    function automatic logic [31:0] pat(input logic pin, input logic [4:0] i);
        return {pin ? 8'h9C : 8'h63, 16'hA50F, 3'h0, i};
    endfunction

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask

    // called right after a rising edge and returns on one, so a read can
    // follow a write with no idle cycle between the strobes
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        @(negedge clock_i);
        `CHK(rd_data_o, e)
        @(posedge clock_i);
    endtask

    // each enabled channel must deliver exactly one word, disabled none
    task automatic run_frame(input logic [1:0] fmt, input logic [4:0] off,
        input logic [2:0] pin, input int nbits, input logic [7:0] c0,
        input logic [7:0] c1, input logic [7:0] c2);
        logic [7:0] c [3];
        c = '{c0, c1, c2};
        reg_wr(ADDR_FMT, {6'h00, fmt});
        reg_wr(ADDR_OFFSET, {3'h0, off});
        reg_wr(ADDR_PINSEL, {5'h00, pin});
        for (int k = 0; k < 3; k++)
            reg_wr(ADDR_CH1 + 8'(k), c[k]);
        @(negedge clock_i);
        vcnt = '{0, 0, 0};
        u_host.send_frame(fmt, int'(off), nbits);
        repeat (12) @(posedge clock_i);
        for (int k = 0; k < 3; k++)
        begin
            `CHK(vcnt[k], int'(c[k][ENABLE_BIT]))
            if (c[k][ENABLE_BIT])
                `CHK(vdat[k], pat(pin[k], c[k][4:0]))
        end
        $display("frame test done, format %0d offset %0d", fmt, off);
    endtask

    initial
    begin
        #5000000;
        num_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        wrap_up();
    end

    initial
    begin
        rst_b_i = 1'b0;
        addr_i = 8'h00;
        wr_data_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        for (int i = 0; i < 32; i++)
        begin
            u_host.word_a[i] = pat(1'b0, 5'(i));
            u_host.word_b[i] = pat(1'b1, 5'(i));
        end
        repeat (3) @(posedge clock_i);
        rst_b_i <= 1'b1;
        reg_rd(ADDR_CH1, 8'h00);
        reg_rd(ADDR_CH2, 8'h01);
        reg_rd(ADDR_CH3, 8'h02);
        reg_rd(8'h30, 8'h00);
        // reserved bits are always written as zero by the host
        reg_wr(ADDR_CH2, 8'h3F);
        reg_rd(ADDR_CH2, 8'h3F);
        reg_wr(ADDR_CH1, 8'h25);
        reg_rd(ADDR_CH1, 8'h25);
        $display("register test done");
        // all frames but the last stop short so the lead-in never lands in a used slot
        run_frame(SPSM_FMT_TDM, 5'h00, 3'h0, 1016,
            8'h20, 8'h2F, 8'h02);
        run_frame(SPSM_FMT_LEFT_JUSTIFIED, 5'h00, 3'h0, 1016,
            8'h30, 8'h21, 8'h3E);
        run_frame(SPSM_FMT_I2S, 5'h03, 3'h1, 1016,
            8'h22, 8'h31, 8'h02);
        run_frame(SPSM_FMT_TDM, 5'h1F, 3'h6, 900,
            8'h05, 8'h34, 8'h20);
        run_frame(SPSM_FMT_TDM, 5'h00, 3'h0, 1024,
            8'h00, 8'h3F, 8'h20);
        wrap_up();
    end
endmodule
`default_nettype wire
